// ==== tsr_defines.svh ====
// Notes on behaviour
// - Writing 1 to reset bit resets the register bank, not the serial engine
// - Mask bit 3 hides accessory change event
// - Mask bit 2 hides current level change
// - Mask bit 1 hides detach event
// - Mask bit 0 hides attach event
// - Status 5:4 reports cable orientation code
// - Status bit 3 shows bus supply valid
// - Status 2:1 reports advertised current level
// - Status bit 0 shows port attached
// - Kind bit 4 marks sink partner
// - Kind bit 3 marks source partner
// - Kind bit 1 marks debug accessory
// - Kind bit 0 marks audio accessory
// - Flag bit 3 latches accessory change
// - Flag bit 2 latches current level change
// - Flag bit 1 latches detach
// - Flag bit 0 latches attach
// - Global mask hides every interrupt source
`ifndef TSR_DEFINES_SVH
`define TSR_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TSR_OFS_CONTROL 8'h03
`define TSR_OFS_SOFT_RESET 8'h05
`define TSR_OFS_EVENT_MASK 8'h10
`define TSR_OFS_PORT_STATUS 8'h11
`define TSR_OFS_PARTNER_KIND 8'h12
`define TSR_OFS_EVENT_FLAGS 8'h13

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TSR_BIT_SOFTWARE_RESET 0
`define TSR_BIT_GLOBAL_MASK 0
`define TSR_BIT_ACC_CHANGE 3
`define TSR_BIT_LEVEL_CHANGE 2
`define TSR_BIT_DETACH 1
`define TSR_BIT_ATTACH 0

// ----------------------------------------
// Reset values, control write mask and slave address
// ----------------------------------------
`define TSR_RST_CONTROL 8'h03
`define TSR_RST_EVENT_MASK 4'h0
`define TSR_RST_EVENT_FLAGS 4'h0
`define TSR_CONTROL_WR_MASK 8'h37
`define TSR_SLAVE_ADDR 7'h3A

`endif

// ==== tsr_pkg.sv ====
// ----------------------------------------
// Shared types
// ----------------------------------------
package tsr_pkg;
	// Serial slave engine states
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_PTR,
		ST_PTR_ACK,
		ST_WDATA,
		ST_WDATA_ACK,
		ST_RDATA,
		ST_MACK
	} tsr_i2c_state_t;
endpackage : tsr_pkg

// ==== tsr_sync2.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Two flop synchroniser for pin levels
// ----------------------------------------
module tsr_sync2 #(
	parameter int W = 1
) (
	input wire logic i_ref_clk,
	input wire logic i_reset,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	// First stage, read only by the second
	logic [W-1:0] meta_reg;

	// Both stages idle high like a released bus
	always_ff @(posedge i_ref_clk)
	begin
		if (i_reset)
		begin
			meta_reg <= '1;
			o_sync <= '1;
		end
		else
		begin
			meta_reg <= i_async;
			o_sync <= meta_reg;
		end
	end
endmodule : tsr_sync2

// ==== tsr_regs.sv ====
`timescale 1ns/1ps
`include "tsr_defines.svh"
// ----------------------------------------
// Type-C status and event register bank
// behind a two wire serial slave port
// ----------------------------------------
module tsr_regs (
	input wire logic i_ref_clk,
	input wire logic i_reset,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe_n,
	output logic o_int_n,
	output logic o_system_reset,
	input wire logic i_attached,
	input wire logic i_accessory_present,
	input wire logic [1:0] i_cable_orientation,
	input wire logic i_bus_supply_valid,
	input wire logic [1:0] i_advertised_current_level,
	input wire logic i_partner_sink,
	input wire logic i_partner_source,
	input wire logic i_debug_accessory_found,
	input wire logic i_audio_accessory_found
);
	// ----------------------------------------
	// Pin synchronisation and bus conditions
	// ----------------------------------------
	logic scl_s; // Synchronised clock pin
	logic sda_s; // Synchronised data pin
	logic scl_d_reg; // Previous clock level
	logic sda_d_reg; // Previous data level
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;

	tsr_sync2 #(.W(2)) u_pin_sync (
		.i_ref_clk(i_ref_clk),
		.i_reset(i_reset),
		.i_async({i_scl, i_sda}),
		.o_sync({scl_s, sda_s})
	);

	// Delayed copies for edge detection
	always_ff @(posedge i_ref_clk)
	begin
		if (i_reset)
		begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end
		else
		begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
		end
	end

	assign scl_rise = scl_s & ~scl_d_reg;
	assign scl_fall = ~scl_s & scl_d_reg;
	// Data moving while clock is high marks frame edges
	assign start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	assign stop_cond = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

	// ----------------------------------------
	// Register storage declarations
	// ----------------------------------------
	logic soft_reset_reg; // One cycle pulse after a reset write
	logic bank_reset; // Hard or software reset of the bank
	logic [7:0] control_reg; // Bit 0 is the global mask
	logic [3:0] event_mask_reg;
	logic [3:0] event_flags_reg;
	logic reg_wr; // Write strobe from the slave engine
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata; // Read mux output
	logic [7:0] port_status;
	logic [7:0] partner_kind;

	assign bank_reset = i_reset | soft_reset_reg;

	// ----------------------------------------
	// Serial slave engine
	// ----------------------------------------
	tsr_pkg::tsr_i2c_state_t state_reg;
	logic [2:0] bit_cnt_reg; // Bit position within a byte
	logic byte_done_reg; // Eighth bit sampled
	logic [7:0] shift_reg; // Byte being moved
	logic [7:0] ptr_reg; // Register pointer, auto increments
	logic drive_low_reg; // Pulls data low when set

	// Bit counter: counts on clock rise when receiving, on clock fall when sending
	always_ff @(posedge i_ref_clk)
	begin
		if (i_reset)
		begin
			bit_cnt_reg <= 3'h0;
			byte_done_reg <= 1'b0;
		end
		else if (start_cond || scl_fall && byte_done_reg)
		begin
			bit_cnt_reg <= 3'h0;
			byte_done_reg <= 1'b0;
		end
		else if (scl_rise && (state_reg == tsr_pkg::ST_ADDR || state_reg == tsr_pkg::ST_PTR
			|| state_reg == tsr_pkg::ST_WDATA))
		begin
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
			byte_done_reg <= (bit_cnt_reg == 3'h7);
		end
		else if (scl_fall && state_reg == tsr_pkg::ST_RDATA)
		begin
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
		end
	end

	// Master acknowledge captured on clock rise
	logic master_nack_reg;
	always_ff @(posedge i_ref_clk)
	begin
		if (i_reset)
		begin
			master_nack_reg <= 1'b1;
		end
		else if (scl_rise && state_reg == tsr_pkg::ST_MACK)
		begin
			master_nack_reg <= sda_s;
		end
	end

	// State, shift register, pointer and data drive
	always_ff @(posedge i_ref_clk)
	begin
		if (i_reset)
		begin
			state_reg <= tsr_pkg::ST_IDLE;
			shift_reg <= 8'h00;
			ptr_reg <= 8'h00;
			drive_low_reg <= 1'b0;
		end
		else if (start_cond)
		begin
			// Repeated start also lands here
			state_reg <= tsr_pkg::ST_ADDR;
			drive_low_reg <= 1'b0;
		end
		else if (stop_cond)
		begin
			state_reg <= tsr_pkg::ST_IDLE;
			drive_low_reg <= 1'b0;
		end
		else if (scl_rise && !byte_done_reg && (state_reg == tsr_pkg::ST_ADDR
			|| state_reg == tsr_pkg::ST_PTR || state_reg == tsr_pkg::ST_WDATA))
		begin
			shift_reg <= {shift_reg[6:0], sda_s};
		end
		else if (scl_fall)
		begin
			unique case (state_reg)
				tsr_pkg::ST_IDLE:
				begin
					drive_low_reg <= 1'b0;
				end
				tsr_pkg::ST_ADDR:
				begin
					// Only answer our own address
					if (byte_done_reg && shift_reg[7:1] == `TSR_SLAVE_ADDR)
					begin
						state_reg <= tsr_pkg::ST_ADDR_ACK;
						drive_low_reg <= 1'b1;
					end
					else if (byte_done_reg)
					begin
						state_reg <= tsr_pkg::ST_IDLE;
					end
				end
				tsr_pkg::ST_ADDR_ACK:
				begin
					if (shift_reg[0])
					begin
						// Read: present first bit now
						state_reg <= tsr_pkg::ST_RDATA;
						shift_reg <= reg_rdata;
						drive_low_reg <= ~reg_rdata[7];
						ptr_reg <= ptr_reg + 8'h01;
					end
					else
					begin
						state_reg <= tsr_pkg::ST_PTR;
						drive_low_reg <= 1'b0;
					end
				end
				tsr_pkg::ST_PTR:
				begin
					if (byte_done_reg)
					begin
						state_reg <= tsr_pkg::ST_PTR_ACK;
						ptr_reg <= shift_reg;
						drive_low_reg <= 1'b1;
					end
				end
				tsr_pkg::ST_PTR_ACK, tsr_pkg::ST_WDATA_ACK:
				begin
					state_reg <= tsr_pkg::ST_WDATA;
					drive_low_reg <= 1'b0;
				end
				tsr_pkg::ST_WDATA:
				begin
					if (byte_done_reg)
					begin
						// Write strobe fires on this edge
						state_reg <= tsr_pkg::ST_WDATA_ACK;
						ptr_reg <= ptr_reg + 8'h01;
						drive_low_reg <= 1'b1;
					end
				end
				tsr_pkg::ST_RDATA:
				begin
					if (bit_cnt_reg == 3'h7)
					begin
						state_reg <= tsr_pkg::ST_MACK;
						drive_low_reg <= 1'b0;
					end
					else
					begin
						shift_reg <= {shift_reg[6:0], 1'b0};
						drive_low_reg <= ~shift_reg[6];
					end
				end
				tsr_pkg::ST_MACK:
				begin
					// Master ack asks for the next byte
					if (!master_nack_reg)
					begin
						state_reg <= tsr_pkg::ST_RDATA;
						shift_reg <= reg_rdata;
						drive_low_reg <= ~reg_rdata[7];
						ptr_reg <= ptr_reg + 8'h01;
					end
					else
					begin
						state_reg <= tsr_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	assign o_sda_out = 1'b0; // Open drain: only ever pulls low
	assign o_sda_oe_n = ~drive_low_reg;
	assign reg_wr = scl_fall && !start_cond && !stop_cond
		&& state_reg == tsr_pkg::ST_WDATA && byte_done_reg;
	assign reg_wdata = shift_reg;

	// ----------------------------------------
	// Software reset
	// ----------------------------------------
	// Pulse lasts one cycle; the bit is not in the read mux and reads as zero
	always_ff @(posedge i_ref_clk)
	begin
		if (i_reset)
		begin
			soft_reset_reg <= 1'b0;
		end
		else
		begin
			soft_reset_reg <= reg_wr && ptr_reg == `TSR_OFS_SOFT_RESET
				&& reg_wdata[`TSR_BIT_SOFTWARE_RESET];
		end
	end

	assign o_system_reset = soft_reset_reg;

	// ----------------------------------------
	// Writable configuration
	// ----------------------------------------
	always_ff @(posedge i_ref_clk)
	begin
		if (bank_reset)
		begin
			control_reg <= `TSR_RST_CONTROL;
			event_mask_reg <= `TSR_RST_EVENT_MASK;
		end
		else if (reg_wr && ptr_reg == `TSR_OFS_CONTROL)
		begin
			control_reg <= reg_wdata & `TSR_CONTROL_WR_MASK;
		end
		else if (reg_wr && ptr_reg == `TSR_OFS_EVENT_MASK)
		begin
			event_mask_reg <= reg_wdata[3:0];
		end
	end

	// ----------------------------------------
	// Event detection
	// ----------------------------------------
	logic attached_d_reg;
	logic [1:0] level_d_reg;
	logic acc_any_d_reg; // Audio or debug seen last cycle
	logic acc_present_d_reg;
	logic acc_any;
	logic [3:0] event_raw;
	logic [3:0] event_set;

	// Previous levels of the detector outputs
	always_ff @(posedge i_ref_clk)
	begin
		if (bank_reset)
		begin
			attached_d_reg <= 1'b0;
			level_d_reg <= 2'h0;
			acc_any_d_reg <= 1'b0;
			acc_present_d_reg <= 1'b0;
		end
		else
		begin
			attached_d_reg <= i_attached;
			level_d_reg <= i_advertised_current_level;
			acc_any_d_reg <= acc_any;
			acc_present_d_reg <= i_accessory_present;
		end
	end

	assign acc_any = i_audio_accessory_found | i_debug_accessory_found;
	always_comb
	begin
		event_raw = 4'h0;
		event_raw[`TSR_BIT_ACC_CHANGE] = acc_present_d_reg & acc_any & ~acc_any_d_reg;
		event_raw[`TSR_BIT_LEVEL_CHANGE] = (level_d_reg != i_advertised_current_level);
		event_raw[`TSR_BIT_DETACH] = attached_d_reg & ~i_attached;
		event_raw[`TSR_BIT_ATTACH] = ~attached_d_reg & i_attached;
	end

	// Masked events never latch, so unmasking shows no stale history
	assign event_set = event_raw & ~event_mask_reg;

	// ----------------------------------------
	// Event flags, write one to clear
	// ----------------------------------------
	always_ff @(posedge i_ref_clk)
	begin
		if (bank_reset)
		begin
			event_flags_reg <= `TSR_RST_EVENT_FLAGS;
		end
		else if (reg_wr && ptr_reg == `TSR_OFS_EVENT_FLAGS)
		begin
			// A new event in the clear cycle survives
			event_flags_reg <= (event_flags_reg & ~reg_wdata[3:0]) | event_set;
		end
		else
		begin
			event_flags_reg <= event_flags_reg | event_set;
		end
	end

	// Interrupt pin, active low, held off by global mask
	assign o_int_n = ~(|event_flags_reg) | control_reg[`TSR_BIT_GLOBAL_MASK];

	// ----------------------------------------
	// Read side
	// ----------------------------------------
	assign port_status = {2'b00, i_cable_orientation, i_bus_supply_valid,
		i_advertised_current_level, i_attached};
	assign partner_kind = {3'b000, i_partner_sink, i_partner_source, 1'b0,
		i_debug_accessory_found, i_audio_accessory_found};

	// Unmapped offsets and the reset register read zero
	always_comb
	begin
		unique case (ptr_reg)
			`TSR_OFS_CONTROL: reg_rdata = control_reg;
			`TSR_OFS_EVENT_MASK: reg_rdata = {4'h0, event_mask_reg};
			`TSR_OFS_PORT_STATUS: reg_rdata = port_status;
			`TSR_OFS_PARTNER_KIND: reg_rdata = partner_kind;
			`TSR_OFS_EVENT_FLAGS: reg_rdata = {4'h0, event_flags_reg};
			default: reg_rdata = 8'h00;
		endcase
	end
endmodule : tsr_regs

// ==== tsr_regs_checker.sv ====
`timescale 1ns/1ps
// --------------------
// Port checks
// --------------------
module tsr_regs_checker (
	input wire logic i_ref_clk,
	input wire logic i_reset,
	input wire logic i_scl,
	input wire logic o_sda_oe_n,
	input wire logic o_int_n,
	input wire logic o_system_reset,
	input wire logic i_attached,
	input wire logic [1:0] i_advertised_current_level,
	input wire logic i_debug_accessory_found,
	input wire logic i_audio_accessory_found
);
	logic att_reg, found_reg; // Last levels
	logic [1:0] lvl_reg; // Last current level
	logic [1:0] hist_reg; // Event in the last two cycles
	logic found; // Either accessory kind
	logic evt; // Superset of flag causes, so looser
	logic quiet; // No recent cause
	assign found = i_debug_accessory_found | i_audio_accessory_found;
	assign evt = (i_attached != att_reg) || (i_advertised_current_level != lvl_reg)
		|| (found && !found_reg);
	assign quiet = !evt && hist_reg == 2'h0;
	// Edge memories, zero after reset like the bank's
	always_ff @(posedge i_ref_clk)
	begin
		if (i_reset)
			{att_reg, found_reg, lvl_reg, hist_reg} <= '0;
		else
			{att_reg, found_reg, lvl_reg, hist_reg} <=
				{i_attached, found, i_advertised_current_level, hist_reg[0], evt};
	end
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_reset);
	a_reset_int_idle: assert property ($fell(i_reset) |-> o_int_n)
		else $error("interrupt active after reset");
	a_reset_no_pulse: assert property ($fell(i_reset) |-> o_sda_oe_n && !o_system_reset)
		else $error("outputs busy after reset");
	a_int_has_cause: assert property ($fell(o_int_n) |-> !quiet || !i_scl)
		else $error("interrupt without a cause");
	a_int_no_event: assert property (o_int_n && i_scl && quiet |=> o_int_n)
		else $error("interrupt raised while quiet");
	a_int_clear_bus: assert property ($rose(o_int_n) |-> !i_scl && !$past(i_scl))
		else $error("interrupt dropped without a write");
	a_swr_bus_write: assert property ($rose(o_system_reset) |-> !i_scl && !$past(i_scl))
		else $error("soft reset without a write");
	a_swr_one_pulse: assert property (o_system_reset |=> !o_system_reset [*8])
		else $error("soft reset pulse too long");
	a_swr_masks_int: assert property (o_system_reset |=> ##1 o_int_n [*4])
		else $error("interrupt active after soft reset");
	c_int_raised: cover property ($fell(o_int_n));
	c_soft_reset: cover property ($rose(o_system_reset));
	c_ack_driven: cover property ($fell(o_sda_oe_n));
endmodule : tsr_regs_checker

bind tsr_regs tsr_regs_checker chk_inst (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
	.i_scl(i_scl), .o_sda_oe_n(o_sda_oe_n), .o_int_n(o_int_n),
	.o_system_reset(o_system_reset), .i_attached(i_attached),
	.i_advertised_current_level(i_advertised_current_level),
	.i_debug_accessory_found(i_debug_accessory_found),
	.i_audio_accessory_found(i_audio_accessory_found));

// ==== tsr_host_model.sv ====
`timescale 1ns/1ps
`include "tsr_defines.svh"
// --------------------
// Serial host model
// --------------------
module tsr_host_model (
	input wire logic i_ref_clk,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda
);
	int nacks = 0; // Missing acks
	// Bus idle, clock stands high
	initial
	begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	// Eight clocks a phase, twice the minimum
	task automatic half;
		repeat (8) @(negedge i_ref_clk);
	endtask : half
	// Start (s=1, also repeated) or stop (s=0)
	task automatic frame(input logic s);
		o_sda = s;
		half();
		o_scl = 1'b1;
		half();
		o_sda = !s;
		half();
		o_scl = !s;
	endtask : frame
	// Drive while low, sample while high
	task automatic bit_io(input logic b, output logic r);
		o_sda = b;
		half();
		o_scl = 1'b1;
		half();
		r = i_sda;
		o_scl = 1'b0;
	endtask : bit_io
	// Eight bits then the ninth; send FF to read
	task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] q,
		output logic k);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(a, k);
	endtask : byte_io
	// Start, write address, pointer
	task automatic head(input logic [7:0] p);
		logic [7:0] q;
		logic [1:0] k;
		frame(1'b1);
		byte_io({`TSR_SLAVE_ADDR, 1'b0}, 1'b1, q, k[0]);
		byte_io(p, 1'b1, q, k[1]);
		nacks += int'(k !== 2'h0);
	endtask : head
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		logic [7:0] q;
		logic k;
		head(p);
		byte_io(d, 1'b1, q, k);
		frame(1'b0);
		nacks += int'(k !== 1'b0);
	endtask : wr
	// Last byte gets no ack, so its ninth bit is ignored
	task automatic rd(input logic [7:0] p, output logic [7:0] d);
		logic [7:0] q;
		logic [1:0] k;
		head(p);
		frame(1'b1);
		byte_io({`TSR_SLAVE_ADDR, 1'b1}, 1'b1, q, k[0]);
		byte_io(8'hFF, 1'b1, d, k[1]);
		frame(1'b0);
		nacks += int'(k[0] !== 1'b0);
	endtask : rd
	// Two bytes, the first acked, so the pointer must step once
	task automatic rd2(input logic [7:0] p, output logic [7:0] d0, output logic [7:0] d1);
		logic [7:0] q;
		logic [2:0] k;
		head(p);
		frame(1'b1);
		byte_io({`TSR_SLAVE_ADDR, 1'b1}, 1'b1, q, k[0]);
		byte_io(8'hFF, 1'b0, d0, k[1]);
		byte_io(8'hFF, 1'b1, d1, k[2]);
		frame(1'b0);
		nacks += int'(k[0] !== 1'b0);
	endtask : rd2
endmodule : tsr_host_model

// ==== tsr_tb.sv ====
`timescale 1ns/1ps
`include "tsr_defines.svh"
// --------------------
// Bench
// --------------------
module tb;
	logic clk, rst, att, acc, vbus, snk, src, dbg, aud; // Clock, reset, status pins
	logic [1:0] ori, lvl; // Orientation, level
	logic h_scl, h_sda, sda_out, sda_oe_n, int_n, sys_rst; // Bus, outputs
	logic [7:0] q, e; // Read data, expected flags
	logic k; // Ninth bit
	wire sda_line; // Wired line with pull-up
	int err_count = 0;
	int comparisons = 0;
	int swr_seen = 0; // Soft reset pulses
	integer seed = 32'h3F45;
	assign sda_line = h_sda & (sda_oe_n | sda_out);
	tsr_regs DUT (.i_ref_clk(clk), .i_reset(rst), .i_scl(h_scl), .i_sda(sda_line),
		.o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n), .o_int_n(int_n), .o_system_reset(sys_rst),
		.i_attached(att), .i_accessory_present(acc), .i_cable_orientation(ori),
		.i_bus_supply_valid(vbus), .i_advertised_current_level(lvl), .i_partner_sink(snk),
		.i_partner_source(src), .i_debug_accessory_found(dbg), .i_audio_accessory_found(aud));
	tsr_host_model host (.i_ref_clk(clk), .i_sda(sda_line), .o_scl(h_scl), .o_sda(h_sda));
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk)
		if (sys_rst === 1'b1)
			swr_seen++;
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Reserved bits are left out of the compare
	task automatic rd_chk(input logic [7:0] p, input logic [7:0] m, input logic [7:0] x);
		host.rd(p, q);
		chk(q & m, x);
	endtask : rd_chk
	function automatic logic [7:0] exp_status();
		return {2'h0, ori, vbus, lvl, att};
	endfunction : exp_status
	function automatic logic [7:0] exp_kind();
		return {3'h0, snk, src, 1'h0, dbg, aud};
	endfunction : exp_kind
	// Event b to its idle (0) or firing (1) side
	task automatic set_ev(input int b, input logic v);
		case (b)
			0: att = v;
			1: att = !v;
			2: lvl = {1'b0, v};
			default:
			begin
				acc = v;
				repeat (2) @(negedge clk);
				{acc, aud} = {1'b0, v};
			end
		endcase
		repeat (4) @(negedge clk);
	endtask : set_ev
	task automatic end_sim;
		$display("Comparisons %0d, mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim
	// Hang guard, about twice the normal run
	initial
	begin
		repeat (95000) @(posedge clk);
		err_count++;
		end_sim();
	end
	initial
	begin
		rst = 1'b1;
		{att, acc, vbus, snk, src, dbg, aud, ori, lvl} = '0;
		repeat (10) @(negedge clk);
		rst = 1'b0;
		chk({7'h00, int_n}, 8'h01);
		rd_chk(`TSR_OFS_EVENT_FLAGS, 8'h0F, 8'h00);
		rd_chk(`TSR_OFS_SOFT_RESET, 8'hFF, 8'h00);
		host.wr(8'h20, 8'hFF);
		rd_chk(8'h20, 8'hFF, 8'h00);
		e = 8'($random(seed));
		host.wr(`TSR_OFS_EVENT_MASK, e);
		rd_chk(`TSR_OFS_EVENT_MASK, 8'h0F, e & 8'h0F);
		// Every orientation and level code
		for (int i = 0; i < 4; i++)
		begin
			ori = 2'(i);
			lvl = 2'(3 - i);
			{att, vbus, snk, src, dbg, aud} = 6'($random(seed));
			host.wr(`TSR_OFS_PORT_STATUS, 8'($random(seed)));
			rd_chk(`TSR_OFS_PORT_STATUS, 8'h3F, exp_status());
			rd_chk(`TSR_OFS_PARTNER_KIND, 8'h1B, exp_kind());
		end
		// Status then kind in one burst, master acks the first byte
		host.rd2(`TSR_OFS_PORT_STATUS, q, e);
		chk(q & 8'h3F, exp_status());
		chk(e & 8'h1B, exp_kind());
		// Each event, masked alone or with all others masked
		dbg = 1'b0;
		host.wr(`TSR_OFS_CONTROL, 8'h02);
		for (int b = 0; b < 4; b++)
			for (int m = 0; m < 2; m++)
			begin
				e = m ? 8'h00 : 8'h01 << b;
				set_ev(b, 1'b0);
				host.wr(`TSR_OFS_EVENT_MASK, m ? 8'h01 << b : 8'h0F ^ (8'h01 << b));
				host.wr(`TSR_OFS_EVENT_FLAGS, 8'h0F);
				set_ev(b, 1'b1);
				chk({7'h00, int_n}, 8'(m));
				rd_chk(`TSR_OFS_EVENT_FLAGS, 8'h0F, e);
				host.wr(`TSR_OFS_EVENT_FLAGS, 8'h00);
				rd_chk(`TSR_OFS_EVENT_FLAGS, 8'h0F, e);
				host.wr(`TSR_OFS_EVENT_FLAGS, e);
				rd_chk(`TSR_OFS_EVENT_FLAGS, 8'h0F, 8'h00);
			end
		// Global mask hides the pin, flag still latches
		host.wr(`TSR_OFS_CONTROL, 8'h03);
		host.wr(`TSR_OFS_EVENT_MASK, 8'h00);
		host.wr(`TSR_OFS_EVENT_FLAGS, 8'h0F);
		set_ev(0, 1'b1);
		chk({7'h00, int_n}, 8'h01);
		rd_chk(`TSR_OFS_EVENT_FLAGS, 8'h0F, 8'h01);
		host.wr(`TSR_OFS_CONTROL, 8'h02);
		chk({7'h00, int_n}, 8'h00);
		// Soft reset with a flag pending; pins idle so nothing refires
		set_ev(3, 1'b0);
		set_ev(0, 1'b0);
		lvl = 2'h0;
		host.wr(`TSR_OFS_EVENT_MASK, 8'h0A);
		host.wr(`TSR_OFS_SOFT_RESET, 8'h01);
		chk(8'(swr_seen), 8'h01);
		chk({7'h00, int_n}, 8'h01);
		rd_chk(`TSR_OFS_EVENT_MASK, 8'h0F, 8'h00);
		rd_chk(`TSR_OFS_EVENT_FLAGS, 8'h0F, 8'h00);
		rd_chk(`TSR_OFS_CONTROL, 8'h01, 8'h01);
		rd_chk(`TSR_OFS_SOFT_RESET, 8'hFF, 8'h00);
		// Foreign address gets no ack
		host.frame(1'b1);
		host.byte_io({`TSR_SLAVE_ADDR ^ 7'h01, 1'b0}, 1'b1, q, k);
		host.frame(1'b0);
		chk({7'h00, k}, 8'h01);
		chk(8'(host.nacks), 8'h00);
		end_sim();
	end
endmodule : tb
